// ---- link_compliance_margin_ctl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lcm_consts.svh"

module link_compliance_margin_ctl
	import lcm_pkg::*;
(
	input  wire logic  clk_sys,          // System clock, 25 MHz.
	input  wire logic  sys_rst,          // Power-on reset, synchronous, returns everything to its reset value.
	input  wire logic  hotRst,           // Link hot reset, leaves sticky fields alone.
	input  wire logic  wb_cyc_i,
	input  wire logic  wb_stb_i,
	input  wire logic  wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire lcm_ltssm_t  ltssmState,       // Training state, same clock.
	input  wire logic        linkAtFastRate,   // High while the link runs at the higher rate.
	output logic [2:0]       txMarginApplied,  // Margin code in use on the line.
	output logic             useLaneDrive,     // High when lane registers set drive level.
	output logic             modCompliancePat, // Send modified compliance pattern.
	output logic             sendSkipOs,       // One-cycle request for a skip set.
	output logic             complianceDeemph, // De-emphasis in compliance, 1 is -3.5 dB.
	output logic             forceCompliance,  // Compliance entry bit towards the link.
	output logic [3:0]       complianceSpeed   // Target speed for compliance.
);

	// Sticky control fields of the second link control register.
	logic [3:0] tls_q;       // Target speed field.
	logic       force_compliance_entry_q;     // Forced compliance entry.
	logic       sde_q;       // Selectable de-emphasis for normal operation.
	logic [2:0] tm_q;        // Transmit margin field as written.
	logic       emc_q;       // Modified compliance enable.
	logic       compliance_skip_insert_q;      // Skip insertion during compliance.
	logic       cde_q;       // Compliance de-emphasis select.

	// Link-facing state, cleared by hot reset as well.
	logic [2:0] tmApplied_q; // Margin code latched at receiver lock.
	logic       viaSw_q;     // Compliance was entered through the entry bit.
	logic       curDe_q;     // De-emphasis in use at the higher rate.
	logic       modPat_q;    // Modified pattern selected for this compliance visit.

	// Bus helpers.
	logic       ack_q;       // Registered acknowledge.
	logic       req;         // A new bus request this cycle.
	logic       wrCtl;       // Write strobe to the control register.
	logic [15:0] wrMask;     // Byte lanes selected by the write.
	logic [15:0] ctlWord;    // Current control register image.
	logic [15:0] ctlNext;    // Control register image after a write.
	logic [31:0] rdData_d;   // Read data for the current address.
	logic       skipTick;    // Skip request from the timer.

	lcm_evt_if evt ();

	// Matches the word address of a request against a register index.
	function automatic logic hitIndex(input logic [9:0] adr, input lcm_index_t idx);
		hitIndex = (adr[9:2] == idx);
	endfunction

	// Training state entries.
	lcm_state_decode uDecode (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.ltssmState (ltssmState),
		.evt        (evt)
	);

	// Skip set pacing while compliance runs with insertion enabled.
	lcm_skip_timer uSkip (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst | hotRst),
		.run     (evt.inPollComp & compliance_skip_insert_q),
		.tick    (skipTick)
	);

	// A request is new while the slave has not yet answered it.
	assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wrCtl = req & wb_we_i & hitIndex(wb_adr_i, `LCM_IDX_LINK_CTL2);

	// Expand the two low byte selects into a bit mask.
	genvar lane;
	generate
		for (lane = 0; lane < 2; lane++) begin : gLane
			assign wrMask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
		end
	endgenerate

	// Image of the control register as software sees it; reserved and hardwired bits are zero.
	always_comb begin
		ctlWord = 16'h0000;
		ctlWord[`LCM_TLS_MSB:`LCM_TLS_LSB] = tls_q;
		ctlWord[`LCM_FORCE_COMPLIANCE_ENTRY_BIT] = force_compliance_entry_q;
		ctlWord[`LCM_HASD_BIT]  = 1'b0;
		ctlWord[`LCM_SDE_BIT]   = sde_q;
		ctlWord[`LCM_TM_MSB:`LCM_TM_LSB] = tm_q;
		ctlWord[`LCM_EMC_BIT]   = emc_q;
		ctlWord[`LCM_COMPLIANCE_SKIP_INSERT_BIT]  = compliance_skip_insert_q;
		ctlWord[`LCM_CDE_BIT]   = cde_q;
	end

	// Merge written byte lanes into the image.
	assign ctlNext = (wb_dat_i[15:0] & wrMask) | (ctlWord & ~wrMask);

	// Acknowledge every request one cycle after it is seen, mapped or not.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	assign wb_ack_o = ack_q;

	// Read multiplexer; slot registers and unmapped addresses read as zero.
	always_comb begin
		rdData_d = 32'h0000_0000;
		unique case (wb_adr_i[9:2])
			`LCM_IDX_LINK_CTL2: begin
				rdData_d[15:0] = ctlWord;
			end
			`LCM_IDX_LINK_STS2: begin
				rdData_d[`LCM_CURDE_BIT] = curDe_q;
			end
			`LCM_IDX_SLOT_CAP2, `LCM_IDX_SLOT_CTL2, `LCM_IDX_SLOT_STS2: begin
				rdData_d = 32'h0000_0000;
			end
			default: begin
				rdData_d = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured with the request so it stands with the acknowledge.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= rdData_d;
		end else if (!req) begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	// Target speed, entry bit and de-emphasis select; only power-on reset clears them.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tls_q   <= `LCM_TLS_RST;
			force_compliance_entry_q <= 1'b0;
			sde_q   <= 1'b0;
		end else if (wrCtl) begin
			tls_q   <= ctlNext[`LCM_TLS_MSB:`LCM_TLS_LSB];
			force_compliance_entry_q <= ctlNext[`LCM_FORCE_COMPLIANCE_ENTRY_BIT];
			sde_q   <= ctlNext[`LCM_SDE_BIT];
		end
	end

	// Compliance test fields; software is expected to leave them at default outside testing.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			emc_q  <= 1'b0;
			compliance_skip_insert_q <= 1'b0;
			cde_q  <= 1'b0;
		end else if (wrCtl) begin
			emc_q  <= ctlNext[`LCM_EMC_BIT];
			compliance_skip_insert_q <= ctlNext[`LCM_COMPLIANCE_SKIP_INSERT_BIT];
			cde_q  <= ctlNext[`LCM_CDE_BIT];
		end
	end

	// Transmit margin as written; entry to polling configuration clears it and wins over a write.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tm_q <= `LCM_TM_RST;
		end else if (evt.pollCfgEntry) begin
			tm_q <= `LCM_TM_NORMAL;
		end else if (wrCtl) begin
			tm_q <= ctlNext[`LCM_TM_MSB:`LCM_TM_LSB];
		end
	end

	// The line only picks up a new margin while passing receiver lock.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || hotRst) begin
			tmApplied_q <= `LCM_TM_NORMAL;
		end else if (evt.pollCfgEntry) begin
			tmApplied_q <= `LCM_TM_NORMAL;
		end else if (evt.rcvrLockEntry) begin
			tmApplied_q <= tm_q;
		end
	end

	// Codes above the last step are reserved; the line stays at its normal range for them.
	always_comb begin
		if (tmApplied_q > `LCM_TM_LAST_LEGAL) begin
			txMarginApplied = `LCM_TM_NORMAL;
		end else begin
			txMarginApplied = tmApplied_q;
		end
	end

	// Normal range hands the drive level to the per-lane drive registers.
	assign useLaneDrive = (txMarginApplied == `LCM_TM_NORMAL);

	// On entry to compliance, note how it was reached and which pattern to send.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || hotRst) begin
			viaSw_q  <= 1'b0;
			modPat_q <= 1'b0;
		end else if (evt.pollCompEntry) begin
			viaSw_q  <= force_compliance_entry_q;
			modPat_q <= emc_q;
		end
	end

	// Modified pattern only while compliance lasts.
	assign modCompliancePat = modPat_q & evt.inPollComp;

	// Skip sets between compliance patterns.
	assign sendSkipOs = skipTick & evt.inPollComp;

	// Software-forced compliance uses its own select; otherwise the normal select.
	assign complianceDeemph = viaSw_q ? cde_q : sde_q;

	// Forced compliance entry and its speed go out to the link layer.
	assign forceCompliance = force_compliance_entry_q;
	assign complianceSpeed = tls_q;

	// Track the de-emphasis in use; at the lower rate the bit holds its last value.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || hotRst) begin
			curDe_q <= 1'b0;
		end else if (linkAtFastRate) begin
			if (evt.inPollComp) begin
				curDe_q <= complianceDeemph;
			end else if (evt.rcvrLockEntry) begin
				curDe_q <= sde_q;
			end
		end
	end
	// The bit is not meaningful while linkAtFastRate is low.

endmodule

`default_nettype wire

// ---- lcm_consts.svh ----
`ifndef LCM_CONSTS_SVH
`define LCM_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define LCM_IDX_LINK_CTL2     8'h70
`define LCM_IDX_LINK_STS2     8'h72
`define LCM_IDX_SLOT_CAP2     8'h74
`define LCM_IDX_SLOT_CTL2     8'h78
`define LCM_IDX_SLOT_STS2     8'h7A

// Field positions inside the second link control register.
`define LCM_TLS_MSB           3
`define LCM_TLS_LSB           0
`define LCM_FORCE_COMPLIANCE_ENTRY_BIT         4
`define LCM_HASD_BIT          5
`define LCM_SDE_BIT           6
`define LCM_TM_MSB            9
`define LCM_TM_LSB            7
`define LCM_EMC_BIT           10
`define LCM_COMPLIANCE_SKIP_INSERT_BIT          11
`define LCM_CDE_BIT           12

// Field position inside the second link status register.
`define LCM_CURDE_BIT         0

// Reset values of the sticky control fields, the normal margin code and the last legal margin code.
`define LCM_TLS_RST           4'h2
`define LCM_TM_RST            3'h0
`define LCM_TM_NORMAL         3'h0
`define LCM_TM_LAST_LEGAL     3'h5

// Spacing of skip ordered sets during compliance, in ns and in clk_sys cycles.
`define LCM_CLK_PERIOD_NS     40
`define LCM_SKIP_PERIOD_NS    4720
`define LCM_SKIP_CYCLES       ((`LCM_SKIP_PERIOD_NS) / (`LCM_CLK_PERIOD_NS))

`endif

// ---- lcm_pkg.sv ----
package lcm_pkg;

	// Training state machine states as reported by the link layer.
	typedef enum logic [3:0] {
		LCM_LT_DETECT     = 4'h0,
		LCM_LT_POLL_ACT   = 4'h1,
		LCM_LT_POLL_CFG   = 4'h2,
		LCM_LT_POLL_COMP  = 4'h3,
		LCM_LT_CONFIG     = 4'h4,
		LCM_LT_L0         = 4'h5,
		LCM_LT_RCV_LOCK   = 4'h6,
		LCM_LT_RCV_SPEED  = 4'h7,
		LCM_LT_RCV_CFG    = 4'h8,
		LCM_LT_RCV_IDLE   = 4'h9,
		LCM_LT_HOT_RESET  = 4'hA,
		LCM_LT_DISABLED   = 4'hB,
		LCM_LT_LOOPBACK   = 4'hC
	} lcm_ltssm_t;

	// Register index as seen on the bus.
	typedef logic [7:0] lcm_index_t;

endpackage

// ---- lcm_evt_if.sv ----
`timescale 1ns/100ps
`default_nettype none

// Entry events of the training state machine, from the decoder to the register bank.
interface lcm_evt_if;
	logic pollCfgEntry;   // One-cycle pulse on entry to polling configuration.
	logic pollCompEntry;  // One-cycle pulse on entry to polling compliance.
	logic rcvrLockEntry;  // One-cycle pulse on entry to recovery receiver lock.
	logic inPollComp;     // Level while in polling compliance.

	modport src (output pollCfgEntry, output pollCompEntry, output rcvrLockEntry,
		output inPollComp);
	modport snk (input pollCfgEntry, input pollCompEntry, input rcvrLockEntry,
		input inPollComp);
endinterface

`default_nettype wire

// ---- lcm_state_decode.sv ----
`timescale 1ns/100ps
`default_nettype none

// Turns the training state into entry pulses, in the same cycle as the state appears.
module lcm_state_decode
	import lcm_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  sys_rst,
	input  wire lcm_ltssm_t ltssmState,
	lcm_evt_if.src     evt
);

	lcm_ltssm_t prevState_q;  // State seen in the previous cycle.

	// Remember the previous state so that entries can be told from stays.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prevState_q <= LCM_LT_DETECT;
		end else begin
			prevState_q <= ltssmState;
		end
	end

	// An entry is a change into the named state.
	assign evt.pollCfgEntry  = (ltssmState == LCM_LT_POLL_CFG) && (prevState_q != LCM_LT_POLL_CFG);
	assign evt.pollCompEntry = (ltssmState == LCM_LT_POLL_COMP)
		&& (prevState_q != LCM_LT_POLL_COMP);
	assign evt.rcvrLockEntry = (ltssmState == LCM_LT_RCV_LOCK) && (prevState_q != LCM_LT_RCV_LOCK);
	assign evt.inPollComp    = (ltssmState == LCM_LT_POLL_COMP);

endmodule

`default_nettype wire

// ---- lcm_skip_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lcm_consts.svh"

// Interval timer, held at zero while run is low, that requests one skip ordered set per period while run is high.
module lcm_skip_timer (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic run,
	output logic      tick
);

	logic [7:0] count_q;  // Cycles since the last request.

	// Count up while running and wrap at the period; stopping rewinds the count.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !run) begin
			count_q <= 8'h00;
			tick    <= 1'b0;
		end else if (count_q == 8'((`LCM_SKIP_CYCLES) - 1)) begin
			count_q <= 8'h00;
			tick    <= 1'b1;
		end else begin
			count_q <= count_q + 8'h01;
			tick    <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ---- lcm_ctl_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

// Watches the register bank's ports and checks the bus and link-side relations.
module lcm_ctl_sva
	import lcm_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        hotRst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire lcm_ltssm_t  ltssmState,
	input wire logic [2:0]  txMarginApplied,
	input wire logic        useLaneDrive,
	input wire logic        modCompliancePat,
	input wire logic        sendSkipOs
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// Applied margin never shows a reserved code.
	chk_margin_legal: assert property (txMarginApplied <= 3'h5)
		else $error("applied margin code is reserved");
	// Lane registers own the drive level exactly when the margin is normal range.
	chk_lane_drive: assert property (useLaneDrive == (txMarginApplied == 3'h0))
		else $error("lane drive select disagrees with margin");
	// The applied margin moves only after receiver lock, a polling clear or a hot reset.
	chk_margin_hold: assert property ($changed(txMarginApplied) |->
		$past(ltssmState) == LCM_LT_RCV_LOCK || $past(ltssmState) == LCM_LT_POLL_CFG
		|| $past(hotRst))
		else $error("applied margin changed outside receiver lock");
	// The modified pattern is only requested around polling compliance.
	chk_mod_scope: assert property (modCompliancePat |-> ltssmState == LCM_LT_POLL_COMP
		|| $past(ltssmState) == LCM_LT_POLL_COMP)
		else $error("modified pattern outside compliance");
	// Skip requests only arise around polling compliance.
	chk_skip_scope: assert property (sendSkipOs |-> ltssmState == LCM_LT_POLL_COMP
		|| $past(ltssmState) == LCM_LT_POLL_COMP)
		else $error("skip request outside compliance");
	// A skip request is a single pulse followed by a quiet gap.
	chk_skip_gap: assert property (sendSkipOs |=> !sendSkipOs [*8])
		else $error("skip requests too close");
	// Every new request is answered next cycle with a one-cycle acknowledge.
	chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("acknowledge missing or too long");
	// Read data is zero whenever no answer is given.
	chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not idle");
	// The upper half of every answer reads zero.
	chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
		else $error("upper read data not zero");

	cover property (sendSkipOs);
	cover property (modCompliancePat);
	cover property ($changed(txMarginApplied));
endmodule

bind link_compliance_margin_ctl lcm_ctl_sva lcm_ctl_sva_inst (.clk_sys, .sys_rst, .hotRst,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .ltssmState, .txMarginApplied,
	.useLaneDrive, .modCompliancePat, .sendSkipOs);

`default_nettype wire

// ---- lcm_link_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

// Far-end port: walks the training states on command, promptly or one cycle per step slower.
module lcm_link_partner
	import lcm_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       go,
	input  wire lcm_ltssm_t goState,
	input  wire logic       slow,
	input  wire logic       forceCompliance,
	input  wire logic [3:0] complianceSpeed,
	output lcm_ltssm_t      ltssmState,
	output logic            linkAtFastRate
);
	logic stepOk_q;  // Halves the step rate when slow is set.

	// State walk; after a hot reset compliance is entered when forced, at the target speed.
	always_ff @(posedge clk_sys) begin
		// The pacing flop starts known, so the slow walk cannot stall on an unknown.
		stepOk_q <= sys_rst ? 1'b0 : !stepOk_q;
		if (sys_rst) begin
			ltssmState <= LCM_LT_DETECT;
		end else if (go) begin
			ltssmState <= goState;
		end else if (!slow || stepOk_q) begin
			case (ltssmState)
				LCM_LT_HOT_RESET: ltssmState <= LCM_LT_POLL_ACT;
				LCM_LT_POLL_ACT: ltssmState <= forceCompliance ? LCM_LT_POLL_COMP
					: LCM_LT_POLL_CFG;
				LCM_LT_POLL_CFG: ltssmState <= LCM_LT_CONFIG;
				LCM_LT_CONFIG: ltssmState <= LCM_LT_L0;
				LCM_LT_RCV_LOCK: ltssmState <= LCM_LT_RCV_CFG;
				LCM_LT_RCV_CFG: ltssmState <= LCM_LT_L0;
				default: ltssmState <= ltssmState;
			endcase
		end
	end

	// The higher rate is used when the target speed asks for it on an active link.
	always_ff @(posedge clk_sys) begin
		linkAtFastRate <= complianceSpeed == 4'h2 && (ltssmState == LCM_LT_L0
			|| ltssmState == LCM_LT_POLL_COMP);
	end
endmodule

`default_nettype wire

// ---- link_compliance_margin_ctl_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lcm_consts.svh"
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin fails++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

// Drives the bank over the bus and the far-end model, checking answers and link outputs.
module link_compliance_margin_ctl_bench
	import lcm_pkg::*;
;
	localparam logic [9:0] aCtl = {`LCM_IDX_LINK_CTL2, 2'b00};
	localparam logic [9:0] aSts = {`LCM_IDX_LINK_STS2, 2'b00};
	logic clk_sys = 1'b0, sys_rst = 1'b1, hotRst = 1'b0, go = 1'b0, slow = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [9:0] wb_adr_i = 10'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, e, d;
	logic [31:0] expQ[$];      // Expected read data, one note per request.
	lcm_ltssm_t ltssmState, goState = LCM_LT_DETECT;
	logic linkAtFastRate, useLaneDrive, modCompliancePat, sendSkipOs;
	logic complianceDeemph, forceCompliance;
	logic [2:0] txMarginApplied, prev;
	logic [3:0] complianceSpeed;
	logic [9:0] roAdr[4] = '{10'h1D0, 10'h1E0, 10'h1E8, 10'h3FC};
	int fails = 0, totalChecks = 0, cycles = 0, n;

	link_compliance_margin_ctl link_compliance_margin_ctl_inst (.clk_sys, .sys_rst, .hotRst,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .ltssmState, .linkAtFastRate, .txMarginApplied, .useLaneDrive,
		.modCompliancePat, .sendSkipOs, .complianceDeemph, .forceCompliance, .complianceSpeed);
	lcm_link_partner lcm_link_partner_inst (.clk_sys, .sys_rst, .go, .goState, .slow,
		.forceCompliance, .complianceSpeed, .ltssmState, .linkAtFastRate);

	initial begin
		forever #20 clk_sys = !clk_sys;
	end

	// Prints the verdict and ends the run.
	task automatic giveVerdict();
		if (fails == 0 && totalChecks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// One classic bus cycle; the expected answer is noted before the request goes out.
	task automatic wbReq(input logic w, input logic [9:0] a, input logic [31:0] v,
		input logic [31:0] x);
		@(posedge clk_sys);
		expQ.push_back(x);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, v, 4'hF};
		do @(negedge clk_sys); while (wb_ack_o !== 1'b1);
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask

	// Sends the far end into a state for one cycle, with an optional hot reset.
	task automatic goTo(input lcm_ltssm_t s, input logic h);
		@(posedge clk_sys);
		{go, goState, hotRst} <= {1'b1, s, h};
		@(posedge clk_sys);
		{go, hotRst} <= 2'b00;
		repeat (6) @(negedge clk_sys);
	endtask

	// Takes the oldest note whenever an answer appears.
	always @(negedge clk_sys) begin
		if (wb_ack_o === 1'b1) begin
			e = (expQ.size() > 0) ? expQ.pop_front() : 32'hDEAD0000;
			`CHK(wb_dat_o, e)
		end
	end

	// Cuts a hang short.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			giveVerdict();
		end
	end

	initial begin
		void'($urandom(32'hDA728BEC));
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		wbReq(1'b0, aCtl, 32'h0, 32'h2);
		`CHK({useLaneDrive, complianceSpeed}, 5'h12)
		foreach (roAdr[i]) begin
			wbReq(1'b1, roAdr[i], 32'hFFFFFFFF, 32'h0);
			wbReq(1'b0, roAdr[i], 32'h0, 32'h0);
		end
		prev = 3'h0;
		for (int c = 0; c < 8; c++) begin
			slow <= c[0];
			d = ($urandom & 32'hFFFFE02F) | (c << 7);
			wbReq(1'b1, aCtl, d, 32'h0);
			wbReq(1'b0, aCtl, 32'h0, {16'h0, d[15:0] & 16'h1FDF});
			`CHK(txMarginApplied, prev)
			goTo(LCM_LT_RCV_LOCK, 1'b0);
			prev = (c > 5) ? 3'h0 : c[2:0];
			`CHK(txMarginApplied, prev)
			`CHK(useLaneDrive, prev == 3'h0)
		end
		slow <= 1'b0;
		wbReq(1'b1, aCtl, 32'h1D92, 32'h0);
		goTo(LCM_LT_HOT_RESET, 1'b1);
		wbReq(1'b0, aCtl, 32'h0, 32'h1D92);
		`CHK({forceCompliance, complianceSpeed}, 5'h12)
		`CHK({modCompliancePat, complianceDeemph}, 2'b11)
		// Status is read only at the higher rate, where it is defined.
		`CHK(linkAtFastRate, 1'b1)
		wbReq(1'b0, aSts, 32'h0, 32'h1);
		n = 0;
		do @(negedge clk_sys); while (sendSkipOs !== 1'b1 && ++n < 400);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (sendSkipOs !== 1'b1 && n < 400);
		`CHK(n, `LCM_SKIP_CYCLES)
		goTo(LCM_LT_POLL_CFG, 1'b0);
		wbReq(1'b0, aCtl, 32'h0, 32'h1C12);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		wbReq(1'b0, aCtl, 32'h0, 32'h2);
		giveVerdict();
	end
endmodule

`default_nettype wire
